// file: hdl/lasr_map.svh
// constants for the linear array section readout
// assumes inclusion by bare name from package and design files
`ifndef LASR_MAP_SVH
`define LASR_MAP_SVH
`define LASR_NUM_SECT 5
`define LASR_PIX_PER_SECT 128
`define LASR_IDX_W 7
`define LASR_END_EDGE 129
`endif

// file: hdl/lasr_pkg.sv
// types shared by the linear array section readout
// assumes lasr_map.svh on the include path
`include "lasr_map.svh"
package lasr_pkg;
   // per-section digital view of the analog output
   typedef struct packed
   {
      logic valid;
      logic [`LASR_IDX_W-1:0] pix_idx;
   } lasr_pix_t;
   typedef enum logic [1:0]
   {
      LASR_IDLE = 2'b01,
      LASR_OUT = 2'b10
   } lasr_state_t;
endpackage

// file: hdl/lasr_top.sv
// five-section linear array readout sequencer, one shared clock
// assumes start inputs come from pins or a controller, async to mclk
`timescale 1ns/100ps
`default_nettype none
`include "lasr_map.svh"

// Contract
// RULE_01 - five 128-pixel sections, one shared clock
// RULE_02 - shared clock alone sequences all readout
// RULE_03 - 128-bit shift register selects pixel
// RULE_04 - start high at edge loads a one; the code loads it two clocks later for a start pin, after the synchroniser
// RULE_05 - one pixel per clock in order
// RULE_06 - reset integrator right after its read
// RULE_07 - end pulse on 129th rising edge
// RULE_08 - new start accepted after end pulse
// RULE_09 - serial mode chains end into next start
// RULE_10 - parallel mode end marks end-of-data
// RULE_11 - last end cascades or marks finish
// RULE_12 - analog output high-z outside output phase
// RULE_13 - controller gives single-clock start pulse
// RULE_14 - valid flag and 7-bit pixel index
module lasr_top
   import lasr_pkg::*;
#(
   parameter int NSECT = `LASR_NUM_SECT,
   parameter int NPIX = `LASR_PIX_PER_SECT
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // serial mode: chain each end pulse into next start
   input wire logic serial_mode,
   // start inputs
   input wire logic start_in_sec1,
   input wire logic start_in_sec2,
   input wire logic start_in_sec3,
   input wire logic start_in_sec4,
   input wire logic start_in_sec5,
   // end outputs
   output logic end_out_sec1,
   output logic end_out_sec2,
   output logic end_out_sec3,
   output logic end_out_sec4,
   output logic end_out_sec5,
   // analog output enables, low while driving
   output logic [NSECT-1:0] pixel_analog_out_oe_n,
   // pixel select and integrator reset, one-hot per section
   output logic [NSECT*NPIX-1:0] pix_select,
   output logic [NSECT*NPIX-1:0] integ_reset,
   // digital view of each section's output
   output var lasr_pix_t [NSECT-1:0] pix_view
);

   // ----------------------------------------
   // parameter check
   // ----------------------------------------
   // port list is fixed at five sections, the index at seven bits
   // refused at elaboration so a bad build never reaches the bench
   generate
      if (NSECT != `LASR_NUM_SECT || NPIX != `LASR_PIX_PER_SECT || NPIX != (1 << `LASR_IDX_W))
      begin : g_bad_param
         $error("lasr_top supports only five sections of 128 pixels");
      end
   endgenerate

   // ----------------------------------------
   // start synchronisation
   // ----------------------------------------
   logic [NSECT-1:0] start_meta_r;
   logic [NSECT-1:0] start_sync_r;
   // serial_mode is a pin too, so it passes the same two flops
   logic serial_meta_r;
   logic serial_sync_r;
   logic [NSECT-1:0] start_pin;
   logic [NSECT-1:0] start_eff;
   logic [NSECT-1:0] end_r;

   assign start_pin = {start_in_sec5, start_in_sec4, start_in_sec3, start_in_sec2, start_in_sec1};

   // trade-off: two clocks of start latency for a clean capture
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         start_meta_r <= '0;
         start_sync_r <= '0;
         serial_meta_r <= 1'b0;
         serial_sync_r <= 1'b0;
      end
      else
      begin
         start_meta_r <= start_pin;
         start_sync_r <= start_meta_r;
         serial_meta_r <= serial_mode;
         serial_sync_r <= serial_meta_r;
      end
   end

   // chained end pulses bypass the synchroniser, they already live on mclk
   always_comb
   begin
      start_eff = start_sync_r;
      if (serial_sync_r)
         start_eff[NSECT-1:1] = end_r[NSECT-2:0]; // see RULE_09
   end

   // ----------------------------------------
   // section sequencers
   // ----------------------------------------
   lasr_state_t state_r [NSECT];
   logic [NPIX-1:0] shift_r [NSECT];
   logic [NPIX-1:0] rst_r [NSECT];

   // ----------------------------------------
   // index helper
   // ----------------------------------------
   // one-hot to index, used for the pixel view
   function automatic logic [`LASR_IDX_W-1:0] onehot_idx(input logic [NPIX-1:0] v);
      logic [`LASR_IDX_W-1:0] idx;
      idx = '0;
      for (int i = 0; i < NPIX; i++)
         if (v[i])
            idx = i[`LASR_IDX_W-1:0];
      return idx;
   endfunction

   // every section runs the same sequencer, no state shared between them
   genvar s;
   generate
      for (s = 0; s < NSECT; s++)
      begin : g_sect
         // shift register: the loaded one walks the array, see RULE_02
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               shift_r[s] <= '0;
               state_r[s] <= LASR_IDLE;
            end
            else
            begin
               case (state_r[s])
                  // a start seen while reading out is dropped without a sign
                  LASR_IDLE:
                  begin
                     if (start_eff[s])
                     begin
                        shift_r[s] <= {{(NPIX-1){1'b0}}, 1'b1}; // see RULE_03 see RULE_04
                        state_r[s] <= LASR_OUT;
                     end
                  end
                  LASR_OUT:
                  begin
                     shift_r[s] <= shift_r[s] << 1; // see RULE_05
                     // no counter: the walking one itself marks the frame end
                     // free again one edge before the end pulse rises
                     if (shift_r[s][NPIX-1])
                        state_r[s] <= LASR_IDLE; // see RULE_08
                  end
                  default:
                  begin
                     shift_r[s] <= '0;
                     state_r[s] <= LASR_IDLE;
                  end
               endcase
            end
         end

         // integrator reset trails the read by one clock, see RULE_06
         // the reset never overlaps the select of the same pixel
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
               rst_r[s] <= '0;
            else
               rst_r[s] <= shift_r[s];
         end

         // end pulse one edge after the last pixel reaches the pins, see RULE_07
         // taken from the delayed select so it trails the registered pixel outputs
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
               end_r[s] <= 1'b0;
            else
               end_r[s] <= rst_r[s][NPIX-1]; // see RULE_10 see RULE_11
         end

         // outputs registered; oe_n high means high impedance, see RULE_12
         // the pin floats between frames, the external pull-down sets its level
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               pixel_analog_out_oe_n[s] <= 1'b1;
               pix_view[s] <= '0;
               pix_select[s*NPIX +: NPIX] <= '0;
               integ_reset[s*NPIX +: NPIX] <= '0;
            end
            else
            begin
               pixel_analog_out_oe_n[s] <= ~(|shift_r[s]);
               pix_view[s].valid <= |shift_r[s]; // see RULE_14
               pix_view[s].pix_idx <= onehot_idx(shift_r[s]);
               pix_select[s*NPIX +: NPIX] <= shift_r[s];
               integ_reset[s*NPIX +: NPIX] <= rst_r[s];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // end outputs
   // ----------------------------------------
   // in serial mode these still pulse, so a host may watch every section
   // end outputs straight from flops, see RULE_01
   assign end_out_sec1 = end_r[0];
   assign end_out_sec2 = end_r[1];
   assign end_out_sec3 = end_r[2];
   assign end_out_sec4 = end_r[3];
   assign end_out_sec5 = end_r[4];

endmodule
`default_nettype wire

// file: testbench/lasr_ctrl.sv
// start-pulse controller facing the five sections
// assumes fire is raised by the bench at an edge
`timescale 1ns/100ps
`default_nettype none
module lasr_ctrl
(
   // clock, reset, request in, starts out
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [4:0] fire,
   output logic [4:0] start
);
   // held request still gives one-clock pulses
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
         start <= 5'h00;
      else
         start <= fire & ~start;
endmodule
`default_nettype wire

// file: testbench/lasr_top_asserts.sv
// port checks, section one in detail
// assumes bind into lasr_top
`timescale 1ns/100ps
`default_nettype none
module lasr_top_asserts
   import lasr_pkg::*;
#(parameter int NSECT = 5, parameter int NPIX = 128)
(
   // watched ports
   input wire logic mclk,
   input wire logic rstn,
   input wire logic start_in_sec1,
   input wire logic end_out_sec1,
   input wire logic [NSECT-1:0] pixel_analog_out_oe_n,
   input wire logic [NSECT*NPIX-1:0] pix_select,
   input wire logic [NSECT*NPIX-1:0] integ_reset,
   input wire lasr_pix_t [NSECT-1:0] pix_view
);
   lasr_pix_t p;
   logic [NPIX-1:0] s;
   assign p = pix_view[0];
   assign s = pix_select[NPIX-1:0];
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   a_oe_tracks: assert property (pixel_analog_out_oe_n[0] == !p.valid) else $error("oe bad");
   a_first_pixel: assert property ($rose(p.valid) |-> p.pix_idx == 7'h00
      && ($past(start_in_sec1, 3) || $past(start_in_sec1, 4))) else $error("first bad");
   a_index_steps: assert property (p.valid && p.pix_idx != 7'h7F |=> p.valid
      && p.pix_idx == $past(p.pix_idx) + 7'h01) else $error("order bad");
   a_end_last: assert property (p.valid && p.pix_idx == 7'h7F |=> end_out_sec1 && !p.valid)
      else $error("no end");
   a_end_single: assert property (end_out_sec1 |=> !end_out_sec1) else $error("end long");
   a_sel_index: assert property (p.valid |-> s[p.pix_idx] && $onehot(s)) else $error("sel bad");
   a_sel_idle: assert property (!p.valid |-> s == '0) else $error("sel idle");
   a_reset_after: assert property (s != '0 |=> integ_reset[NPIX-1:0] == $past(s))
      else $error("reset bad");
   c_read: cover property (end_out_sec1);
   c_again: cover property (end_out_sec1 ##[1:8] $rose(p.valid));
   c_last: cover property (!pixel_analog_out_oe_n[NSECT-1]);
endmodule
bind lasr_top lasr_top_asserts #(.NSECT(NSECT), .NPIX(NPIX)) lasr_top_asserts_i
   (.mclk(mclk), .rstn(rstn), .start_in_sec1(start_in_sec1), .end_out_sec1(end_out_sec1),
   .pixel_analog_out_oe_n(pixel_analog_out_oe_n), .pix_select(pix_select),
   .integ_reset(integ_reset), .pix_view(pix_view));
`default_nettype wire

// file: testbench/tb.sv
// bench: single, refused, parallel, serial
// assumes lasr_ctrl drives the starts
`timescale 1ns/100ps
`default_nettype none
module tb;
   import lasr_pkg::*;
   logic mclk = 1'b0, rstn = 1'b0, serial_mode = 1'b0;
   logic [4:0] fire = 5'h00, st, eo, oe_n;
   logic [639:0] sel;
   lasr_pix_t [4:0] pv;
   int err_total = 0, samples_checked = 0;
   initial forever #25 mclk = ~mclk;
   lasr_ctrl lasr_ctrl_i (.mclk(mclk), .rstn(rstn), .fire(fire), .start(st));
   lasr_top lasr_top_i (.mclk(mclk), .rstn(rstn), .serial_mode(serial_mode), .start_in_sec1(st[0]),
      .start_in_sec2(st[1]), .start_in_sec3(st[2]), .start_in_sec4(st[3]), .start_in_sec5(st[4]),
      .end_out_sec1(eo[0]), .end_out_sec2(eo[1]), .end_out_sec3(eo[2]), .end_out_sec4(eo[3]),
      .end_out_sec5(eo[4]), .pixel_analog_out_oe_n(oe_n), .pix_select(sel), .integ_reset(), .pix_view(pv));
   task print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(string w, logic [9:0] e, logic [9:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s exp %0h got %0h", w, e, g);
      end
   endtask
   // bounded wait, sync latency is not exact
   task go(logic [4:0] m, int k);
      @(posedge mclk) fire <= m;
      @(posedge mclk) fire <= 5'h00;
      for (int n = 0; n < 6 && pv[k].valid !== 1'b1; n++)
         @(posedge mclk) #1;
      chk("start", 10'h001, {9'h000, pv[k].valid});
      if (pv[k].valid !== 1'b1)
         print_verdict();
   endtask
   task t_single();
      go(5'h01, 0);
      for (int i = 0; i < 128; i++)
      begin
         chk("pixel", {3'b011, i[6:0]}, {oe_n[0], sel[i], pv[0].valid, pv[0].pix_idx});
         fire <= {4'h0, i == 60};
         @(posedge mclk) #1;
      end
      chk("end", 10'h005, {7'h00, eo[0], pv[0].valid, oe_n[0]});
      go(5'h01, 0);
      repeat (130) @(posedge mclk);
      $display("t_single done");
   endtask
   task t_par();
      go(5'h1E, 1);
      chk("par oe", 10'h001, {5'h00, oe_n});
      repeat (128) @(posedge mclk);
      #1 chk("par end", 10'h01E, {5'h00, eo});
      $display("t_par done");
   endtask
   task t_ser();
      int n = 0;
      serial_mode <= 1'b1;
      go(5'h01, 0);
      for (int c = 0; c < 700 && eo[4] !== 1'b1; c++)
      begin
         n += $countones(~oe_n);
         @(posedge mclk) #1;
      end
      chk("serial pixels", 10'd640, n[9:0]);
      chk("last end", 10'h001, {9'h000, eo[4]});
      $display("t_ser done");
   endtask
   initial
   begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      t_single();
      t_par();
      t_ser();
      print_verdict();
   end
endmodule
`default_nettype wire
